// File: hdl/trwu_pkg.sv
// Package for the table read/write unit: register map, fields, types
package trwu_pkg;

  // Register byte addresses
  localparam logic [11:0] ADDR_RESET_CONTROL_STATUS = 12'h0fd0;
  localparam logic [11:0] ADDR_TABLE_LATCH          = 12'h0ff5;
  localparam logic [11:0] ADDR_TABLE_POINTER_LOW    = 12'h0ff6;
  localparam logic [11:0] ADDR_TABLE_POINTER_HIGH   = 12'h0ff7;
  localparam logic [11:0] ADDR_TABLE_POINTER_UPPER  = 12'h0ff8;

  // Reset-control status field positions
  localparam int BIT_IRQ_PRIORITY_ENABLE = 7;
  localparam int BIT_LONG_WRITE_ENABLE   = 6;
  localparam int BIT_UNUSED              = 5;
  localparam int BIT_RESET_INSTR         = 4;
  localparam int BIT_WATCHDOG_TIMEOUT    = 3;
  localparam int BIT_SLEEP_ENTERED       = 2;
  localparam int BIT_POWER_ON_RESET      = 1;
  localparam int BIT_BROWNOUT_RESET      = 0;

  // Reset-control status writable mask and power-on value
  localparam logic [7:0] RCS_WRITE_MASK = 8'hc3;
  localparam logic [7:0] RCS_POR_VALUE  = 8'h1c;

  // Pointer geometry
  localparam int PTR_WIDTH  = 22;
  localparam int PROG_WIDTH = 21;
  localparam int UPPER_BITS = 6;

  // Pointer action encoding on the core command port
  typedef enum logic [1:0] {
    PTR_KEEP     = 2'b00,
    PTR_POST_INC = 2'b01,
    PTR_POST_DEC = 2'b10,
    PTR_PRE_INC  = 2'b11
  } trwu_ptr_mode_t;

  // Table command from the core
  typedef struct packed {
    logic           read;
    logic           write;
    trwu_ptr_mode_t mode;
  } trwu_cmd_t;

  // Program memory port toward the array
  typedef struct packed {
    logic [PTR_WIDTH-1:0] addr;
    logic                 readEn;
    logic                 shortWr;
    logic                 longWr;
    logic [15:0]          wrWord;
  } trwu_mem_req_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_READ    = 2'b01,
    ST_PROGRAM = 2'b10
  } trwu_state_t;

endpackage : trwu_pkg

// File: hdl/trwu_table_unit.sv
// Table read/write unit with reset-control status register
module trwu_table_unit
  import trwu_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 clkEn,
  // Reset causes and status events, one-cycle pulses from the core
  input  wire logic                 powerOnReset,
  input  wire logic                 masterClearReset,
  input  wire logic                 brownoutReset,
  input  wire logic                 resetInstr,
  input  wire logic                 watchdogClearInstr,
  input  wire logic                 sleepInstr,
  input  wire logic                 watchdogTimeout,
  // Register port
  input  wire logic [11:0]          regAddr,
  input  wire logic [7:0]           regWrData,
  input  wire logic                 regWrEn,
  input  wire logic                 regRdEn,
  output logic      [7:0]           regRdData,
  // Table command port
  input  wire trwu_cmd_t            tableCmd,
  input  wire logic                 externalMem,
  output logic                      tableDone,
  output logic                      coreHalt,
  // Program memory side
  output trwu_mem_req_t             memReq,
  input  wire logic [7:0]           memRdData,
  input  wire logic                 programVoltagePin,
  input  wire logic                 irqTerminate,
  // Status
  output logic                      irqPriorityMode,
  output logic                      readOnlyFault
);

  // Register state
  logic [7:0]           rcs_q;
  logic [7:0]           latch_q;
  logic [PTR_WIDTH-1:0] ptr_q;
  logic [7:0]           hold_q;
  logic [7:0]           rdData_q;
  trwu_state_t          state_q;
  logic                 vppMeta_q;
  logic                 vppSync_q;
  trwu_mem_req_t        memReq_q;
  logic                 done_q;
  logic                 halt_q;
  logic                 prio_q;
  logic                 roFault_q;

  // Address decode
  wire selRcs   = regAddr == ADDR_RESET_CONTROL_STATUS;
  wire selLatch = regAddr == ADDR_TABLE_LATCH;
  wire selLow   = regAddr == ADDR_TABLE_POINTER_LOW;
  wire selHigh  = regAddr == ADDR_TABLE_POINTER_HIGH;
  wire selUpper = regAddr == ADDR_TABLE_POINTER_UPPER;

  // Pointer arithmetic; top bit held apart so carries never reach it
  wire [PROG_WIDTH-1:0] ptrInc = ptr_q[PROG_WIDTH-1:0] + 21'h00_0001;
  wire [PROG_WIDTH-1:0] ptrDec = ptr_q[PROG_WIDTH-1:0] - 21'h00_0001;
  wire [PTR_WIDTH-1:0]  ptrIncFull = {ptr_q[PTR_WIDTH-1], ptrInc};
  wire [PTR_WIDTH-1:0]  ptrDecFull = {ptr_q[PTR_WIDTH-1], ptrDec};

  // Command qualification, only when the sequencer is idle
  wire idle      = state_q == ST_IDLE;
  wire cmdRead   = idle && tableCmd.read;
  wire cmdWrite  = idle && tableCmd.write && !tableCmd.read;
  wire preInc    = tableCmd.mode == PTR_PRE_INC;
  wire [PTR_WIDTH-1:0] accAddr = preInc ? ptrIncFull : ptr_q;
  wire accRo     = accAddr[PTR_WIDTH-1];
  wire accOdd    = accAddr[0];
  // Internal array needs enable and programming voltage; external ignores enable
  wire intWriteOk = rcs_q[BIT_LONG_WRITE_ENABLE] && vppSync_q;
  wire longOk    = externalMem || intWriteOk;
  wire startLong = cmdWrite && accOdd && !accRo && longOk;
  wire shortEven = cmdWrite && !accOdd && !accRo;
  wire roWrite   = cmdWrite && accRo;

  // Pointer value after a command's own update
  logic [PTR_WIDTH-1:0] ptrAfter;
  always_comb begin
    unique case (tableCmd.mode)
      PTR_KEEP:     ptrAfter = ptr_q;
      PTR_POST_INC: ptrAfter = ptrIncFull;
      PTR_POST_DEC: ptrAfter = ptrDecFull;
      PTR_PRE_INC:  ptrAfter = ptrIncFull;
    endcase
  end

  // Programming voltage pin synchroniser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vppMeta_q <= 1'b0;
      vppSync_q <= 1'b0;
    end else if (clkEn) begin
      vppMeta_q <= programVoltagePin;
      vppSync_q <= vppMeta_q;
    end
  end

  // Reset-control status next value; hardware events win over software writes
  logic [7:0] rcs_d;
  always_comb begin
    rcs_d = rcs_q;
    if (regWrEn && selRcs) begin
      rcs_d = (rcs_q & ~RCS_WRITE_MASK) | (regWrData & RCS_WRITE_MASK);
    end
    if (powerOnReset) begin
      rcs_d = RCS_POR_VALUE;
      rcs_d[BIT_IRQ_PRIORITY_ENABLE] = 1'b0;
    end else begin
      if (masterClearReset) begin
        rcs_d[BIT_LONG_WRITE_ENABLE] = 1'b0;
      end else if (regWrEn && selRcs && !regWrData[BIT_LONG_WRITE_ENABLE]) begin
        rcs_d[BIT_LONG_WRITE_ENABLE] = rcs_q[BIT_LONG_WRITE_ENABLE];
      end
      if (brownoutReset) begin
        rcs_d[BIT_BROWNOUT_RESET] = 1'b0;
      end
      if (resetInstr) begin
        rcs_d[BIT_RESET_INSTR] = 1'b0;
      end
      if (watchdogClearInstr) begin
        rcs_d[BIT_WATCHDOG_TIMEOUT] = 1'b1;
        rcs_d[BIT_SLEEP_ENTERED]    = 1'b1;
      end
      if (sleepInstr) begin
        rcs_d[BIT_WATCHDOG_TIMEOUT] = 1'b1;
        rcs_d[BIT_SLEEP_ENTERED]    = 1'b0;
      end
      if (watchdogTimeout) begin
        rcs_d[BIT_WATCHDOG_TIMEOUT] = 1'b0;
      end
    end
    rcs_d[BIT_UNUSED] = 1'b0;
  end

  // Status register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rcs_q <= RCS_POR_VALUE;
    end else if (clkEn) begin
      rcs_q <= rcs_d;
    end
  end

  // Read mux; the holding register has no address
  logic [7:0] rdMux;
  always_comb begin
    rdMux = 8'h00;
    if (selRcs) begin
      rdMux = rcs_q;
    end else if (selLatch) begin
      rdMux = latch_q;
    end else if (selLow) begin
      rdMux = ptr_q[7:0];
    end else if (selHigh) begin
      rdMux = ptr_q[15:8];
    end else if (selUpper) begin
      rdMux = {2'b00, ptr_q[PTR_WIDTH-1:16]};
    end
  end

  // Read data register, valid the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_q <= 8'h00;
    end else if (clkEn && regRdEn) begin
      rdData_q <= rdMux;
    end
  end

  // Table latch: software write or byte fetched by a read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_q <= 8'h00;
    end else if (clkEn) begin
      if (state_q == ST_READ) begin
        latch_q <= memRdData;
      end else if (regWrEn && selLatch) begin
        latch_q <= regWrData;
      end
    end
  end

  // Holding register for the even byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_q <= 8'h00;
    end else if (clkEn && (shortEven || (cmdWrite && accOdd && !accRo && !longOk))) begin
      hold_q <= shortEven ? latch_q : hold_q;
    end
  end

  // Pointer: three byte registers joined into one 22-bit value
  logic [PTR_WIDTH-1:0] ptr_d;
  always_comb begin
    ptr_d = ptr_q;
    if (cmdRead || cmdWrite) begin
      ptr_d = ptrAfter;
    end else if (regWrEn && selLow) begin
      ptr_d[7:0] = regWrData;
    end else if (regWrEn && selHigh) begin
      ptr_d[15:8] = regWrData;
    end else if (regWrEn && selUpper) begin
      ptr_d[PTR_WIDTH-1:16] = regWrData[UPPER_BITS-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_q <= '0;
    end else if (clkEn) begin
      ptr_q <= ptr_d;
    end
  end

  // Sequencer: read takes one fetch cycle, long write halts until ended
  trwu_state_t state_d;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (cmdRead) begin
          state_d = ST_READ;
        end else if (startLong) begin
          state_d = ST_PROGRAM;
        end
      end
      ST_READ: begin
        state_d = ST_IDLE;
      end
      ST_PROGRAM: begin
        if (irqTerminate || masterClearReset || powerOnReset || brownoutReset) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
    end else if (clkEn) begin
      state_q <= state_d;
    end
  end

  // Memory request; address kept for the fetch, word formed for programming
  trwu_mem_req_t memReq_d;
  always_comb begin
    memReq_d         = memReq_q;
    memReq_d.readEn  = cmdRead;
    memReq_d.shortWr = shortEven;
    memReq_d.longWr  = startLong || (state_q == ST_PROGRAM && state_d == ST_PROGRAM);
    if (cmdRead || cmdWrite) begin
      memReq_d.addr = accAddr;
    end
    if (startLong) begin
      memReq_d.wrWord = {latch_q, hold_q};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      memReq_q <= '0;
    end else if (clkEn) begin
      memReq_q <= memReq_d;
    end
  end

  // Completion, halt and status outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_q    <= 1'b0;
      halt_q    <= 1'b0;
      prio_q    <= 1'b0;
      roFault_q <= 1'b0;
    end else if (clkEn) begin
      done_q    <= (state_q == ST_READ) || (cmdWrite && !startLong)
                   || (state_q == ST_PROGRAM && state_d == ST_IDLE);
      halt_q    <= state_d == ST_PROGRAM;
      prio_q    <= rcs_d[BIT_IRQ_PRIORITY_ENABLE];
      roFault_q <= roWrite;
    end
  end

  // Output drive from flip-flops
  assign regRdData       = rdData_q;
  assign memReq          = memReq_q;
  assign tableDone       = done_q;
  assign coreHalt        = halt_q;
  assign irqPriorityMode = prio_q;
  assign readOnlyFault   = roFault_q;

  // Status register checks; each event flag is looked at one cycle after its event, the unused bit and priority mirror every cycle
  a_unused_bit_zero: assert property (@(posedge clk) disable iff (!reset_n)
    rcs_q[BIT_UNUSED] == 1'b0) else $error("unused status bit set");
  a_enable_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && rcs_q[BIT_LONG_WRITE_ENABLE] && !powerOnReset && !masterClearReset
    |=> rcs_q[BIT_LONG_WRITE_ENABLE]) else $error("long-write enable dropped");
  a_pin_reset_enable: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && masterClearReset |=> !rcs_q[BIT_LONG_WRITE_ENABLE]) else $error("pin reset kept write enable");
  a_por_clears_flags: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && powerOnReset |=> !rcs_q[BIT_POWER_ON_RESET] && !rcs_q[BIT_BROWNOUT_RESET])
    else $error("power-on reset flags not cleared");
  a_brownout_clears: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && brownoutReset |=> !rcs_q[BIT_BROWNOUT_RESET]) else $error("brown-out flag not cleared");
  a_sleep_flags: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && sleepInstr && !watchdogTimeout && !powerOnReset
    |=> !rcs_q[BIT_SLEEP_ENTERED] && rcs_q[BIT_WATCHDOG_TIMEOUT]) else $error("sleep flags wrong");
  a_wdclear_flags: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && watchdogClearInstr && !sleepInstr && !watchdogTimeout && !powerOnReset
    |=> rcs_q[BIT_WATCHDOG_TIMEOUT] && rcs_q[BIT_SLEEP_ENTERED]) else $error("watchdog clear flags wrong");
  a_timeout_clears: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && watchdogTimeout && !powerOnReset |=> !rcs_q[BIT_WATCHDOG_TIMEOUT])
    else $error("time-out flag not cleared");
  a_reset_instr: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && resetInstr && !powerOnReset |=> !rcs_q[BIT_RESET_INSTR]) else $error("reset flag not cleared");
  a_prio_mirror: assert property (@(posedge clk) disable iff (!reset_n)
    irqPriorityMode == rcs_q[BIT_IRQ_PRIORITY_ENABLE]) else $error("priority mode differs from status bit");

  // Table command checks
  a_top_bit_kept: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && (cmdRead || cmdWrite) |=> ptr_q[PTR_WIDTH-1] == $past(ptr_q[PTR_WIDTH-1]))
    else $error("pointer top bit changed");
  a_pre_inc_read: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && cmdRead && tableCmd.mode == PTR_PRE_INC
    |=> memReq_q.readEn && memReq_q.addr[PROG_WIDTH-1:0] == $past(ptr_q[PROG_WIDTH-1:0]) + 21'h00_0001)
    else $error("pre-increment address wrong");
  a_post_dec_ptr: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && cmdRead && tableCmd.mode == PTR_POST_DEC
    |=> ptr_q[PROG_WIDTH-1:0] == $past(ptr_q[PROG_WIDTH-1:0]) - 21'h00_0001) else $error("post-decrement wrong");
  a_low_byte_write: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && regWrEn && selLow && !cmdRead && !cmdWrite |=> ptr_q[7:0] == $past(regWrData))
    else $error("pointer low byte not written");
  a_read_fills_latch: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && state_q == ST_READ |=> latch_q == $past(memRdData)) else $error("latch not loaded");
  a_even_short: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && shortEven |=> memReq_q.shortWr && !memReq_q.longWr && hold_q == $past(latch_q))
    else $error("even write not short");
  a_no_long_locked: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && cmdWrite && !externalMem && !intWriteOk |=> !memReq_q.longWr)
    else $error("long write without enable");
  a_halt_program: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && startLong |=> coreHalt && memReq_q.wrWord == {$past(latch_q), $past(hold_q)})
    else $error("long write did not halt");
  a_long_odd_only: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && memReq_q.longWr |-> memReq_q.addr[0] && !memReq_q.addr[PTR_WIDTH-1])
    else $error("long write at even or read-only address");
  a_halt_until_end: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && state_q == ST_PROGRAM && !irqTerminate && !masterClearReset && !powerOnReset && !brownoutReset
    |=> coreHalt) else $error("halt ended early");
  a_reset_ends_long: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && state_q == ST_PROGRAM && (masterClearReset || powerOnReset || brownoutReset)
    |=> !coreHalt && tableDone) else $error("reset did not end long write");
  a_irq_ends_long: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && state_q == ST_PROGRAM && irqTerminate |=> !coreHalt && tableDone)
    else $error("interrupt did not end long write");
  a_ro_no_write: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && roWrite |=> !memReq_q.longWr && !memReq_q.shortWr) else $error("write to read-only space");

  // Cover points for the main scenarios
  c_read: cover property (@(posedge clk) disable iff (!reset_n) state_q == ST_READ);
  c_long: cover property (@(posedge clk) disable iff (!reset_n) startLong);
  c_end_long: cover property (@(posedge clk) disable iff (!reset_n)
    state_q == ST_PROGRAM && irqTerminate);
  c_reset_end: cover property (@(posedge clk) disable iff (!reset_n)
    state_q == ST_PROGRAM && brownoutReset);
  c_ro_write: cover property (@(posedge clk) disable iff (!reset_n) roWrite);

endmodule : trwu_table_unit

// File: verification/trwu_mem_model.sv
// Program memory model facing the table unit's memory port
module trwu_mem_model
  import trwu_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // Memory port
  input  wire trwu_mem_req_t memReq,
  output logic [7:0]         memRdData,
  // Long write observation
  output logic [7:0]         longCount,
  output logic [15:0]        lastWord,
  output logic [21:0]        lastAddr
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       longWrPrev;
  logic [7:0] cellByte;

  // Contents are a fixed pattern of the address, so any byte is predictable
  assign cellByte  = memReq.addr[7:0] ^ {2'h0, memReq.addr[21:16]} ^ 8'h5a;
  // Bus not enabled shows the inverse, never a stale copy
  assign memRdData = memReq.readEn ? cellByte : ~cellByte;

  // Record each programming pulse once, at its start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      longWrPrev <= 1'b0;
      longCount  <= 8'h00;
      lastWord   <= 16'h0000;
      lastAddr   <= 22'h00_0000;
    end else begin
      longWrPrev <= memReq.longWr;
      if (memReq.longWr && !longWrPrev) begin
        longCount <= longCount + 8'h01;
        lastWord  <= memReq.wrWord;
        lastAddr  <= memReq.addr;
      end
    end
  end
endmodule : trwu_mem_model

// File: verification/test_table_read_write_unit.sv
// Self-checking bench for the table read/write unit
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module test_table_read_write_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import trwu_pkg::*;

  logic clk = 0, reset_n = 0, externalMem = 0, programVoltagePin = 1, irqTerminate = 0;
  logic [6:0] evts = '0;
  logic [11:0] regAddr = '0;
  logic [7:0] regWrData = '0, regRdData, memRdData, longCount;
  logic regWrEn = 0, regRdEn = 0, tableDone, coreHalt, irqPriorityMode, readOnlyFault;
  trwu_cmd_t tableCmd = '0;
  trwu_mem_req_t memReq;
  logic [15:0] lastWord;
  logic [21:0] lastAddr, p, a;
  logic [7:0] evExp [7] = '{8'h1c, 8'h5f, 8'h5b, 8'h53, 8'h5f, 8'h4f, 8'h4e};
  int evIdx [7] = '{0, 0, 5, 6, 4, 3, 2};
  logic [21:0] starts [3] = '{22'h00_0010, 22'h1f_ffff, 22'h3f_ffff};
  int num_errors = 0, samples_checked = 0, haltSeen, haltCnt = 0;
  logic faultSeen;

  always #5 clk = ~clk;

  trwu_table_unit DUT (.clk(clk), .reset_n(reset_n), .clkEn(1'b1), .powerOnReset(evts[0]),
    .masterClearReset(evts[1]), .brownoutReset(evts[2]), .resetInstr(evts[3]),
    .watchdogClearInstr(evts[4]), .sleepInstr(evts[5]), .watchdogTimeout(evts[6]),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .tableCmd(tableCmd), .externalMem(externalMem), .tableDone(tableDone),
    .coreHalt(coreHalt), .memReq(memReq), .memRdData(memRdData), .programVoltagePin(programVoltagePin),
    .irqTerminate(irqTerminate), .irqPriorityMode(irqPriorityMode), .readOnlyFault(readOnlyFault));

  trwu_mem_model memModel (.clk(clk), .reset_n(reset_n), .memReq(memReq), .memRdData(memRdData),
    .longCount(longCount), .lastWord(lastWord), .lastAddr(lastAddr));

  // Interrupt that ends a long write after six halted cycles
  always @(posedge clk) begin
    haltCnt <= (coreHalt === 1'b1) ? haltCnt + 1 : 0;
    irqTerminate <= (haltCnt == 5);
  end

  task automatic wr(input logic [11:0] ad, input logic [7:0] d);
    @(posedge clk);
    regAddr <= ad; regWrData <= d; regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] ad, input logic [7:0] e);
    @(posedge clk);
    regAddr <= ad; regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(negedge clk);
    `CHK(regRdData, e)
  endtask : rd

  task automatic ev(input int idx);
    @(posedge clk);
    evts[idx] <= 1'b1;
    @(posedge clk);
    evts <= '0;
  endtask : ev

  task automatic setPtr(input logic [21:0] v);
    wr(ADDR_TABLE_POINTER_LOW, v[7:0]);
    wr(ADDR_TABLE_POINTER_HIGH, v[15:8]);
    wr(ADDR_TABLE_POINTER_UPPER, {2'h0, v[21:16]});
  endtask : setPtr

  task automatic rdPtr(input logic [21:0] e);
    rd(ADDR_TABLE_POINTER_LOW, e[7:0]);
    rd(ADDR_TABLE_POINTER_HIGH, e[15:8]);
    rd(ADDR_TABLE_POINTER_UPPER, {2'h0, e[21:16]});
  endtask : rdPtr

  // One table command, then wait for its end while noting halt and fault
  task automatic cmd(input logic r, input logic w, input trwu_ptr_mode_t m);
    haltSeen = 0;
    faultSeen = 1'b0;
    @(posedge clk);
    tableCmd <= '{read: r, write: w, mode: m};
    @(posedge clk);
    tableCmd <= '0;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (coreHalt === 1'b1) haltSeen++;
      if (readOnlyFault === 1'b1) faultSeen = 1'b1;
      if (tableDone === 1'b1) break;
    end
    `CHK(tableDone, 1'b1)
  endtask : cmd

  // Pointer step on the low 21 bits only
  function automatic logic [21:0] step(input logic [21:0] v, input logic up);
    return {v[21], up ? v[20:0] + 21'h00_0001 : v[20:0] - 21'h00_0001};
  endfunction : step

  task automatic print_verdict;
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rd(ADDR_RESET_CONTROL_STATUS, RCS_POR_VALUE);
    wr(ADDR_RESET_CONTROL_STATUS, 8'hff);
    rd(ADDR_RESET_CONTROL_STATUS, 8'hdf);
    @(negedge clk);
    `CHK(irqPriorityMode, 1'b1)
    wr(ADDR_RESET_CONTROL_STATUS, 8'h03);
    rd(ADDR_RESET_CONTROL_STATUS, 8'h5f);
    @(negedge clk);
    `CHK(irqPriorityMode, 1'b0)
    // Sleep, time-out, watchdog clear, reset instruction, brown-out, pin, power-on
    for (int i = 2; i < 7; i++) begin
      ev(evIdx[i]);
      rd(ADDR_RESET_CONTROL_STATUS, evExp[i]);
    end
    ev(1);
    rd(ADDR_RESET_CONTROL_STATUS, 8'h0e);
    ev(0);
    rd(ADDR_RESET_CONTROL_STATUS, 8'h1c);
    wr(ADDR_TABLE_POINTER_UPPER, 8'hff);
    rd(ADDR_TABLE_POINTER_UPPER, 8'h3f);
    rd(12'h0000, 8'h00);
    // Every pointer action from three starting points, including wraps
    foreach (starts[s]) begin
      p = starts[s];
      setPtr(p);
      for (int m = 0; m < 4; m++) begin
        a = (m == 3) ? step(p, 1'b1) : p;
        cmd(1'b1, 1'b0, trwu_ptr_mode_t'(m));
        rd(ADDR_TABLE_LATCH, a[7:0] ^ {2'h0, a[21:16]} ^ 8'h5a);
        p = (m == 0) ? p : step(p, m != 2);
        rdPtr(p);
      end
    end
    // Even then odd write with the long-write enable clear
    setPtr(22'h00_0100);
    wr(ADDR_TABLE_LATCH, 8'h34);
    cmd(1'b0, 1'b1, PTR_POST_INC);
    `CHK(longCount, 8'h00)
    rdPtr(22'h00_0101);
    wr(ADDR_TABLE_LATCH, 8'h12);
    cmd(1'b0, 1'b1, PTR_KEEP);
    `CHK(longCount, 8'h00)
    `CHK(haltSeen, 0)
    // Single word update as software should do it, enable set
    wr(ADDR_RESET_CONTROL_STATUS, 8'h40);
    rd(ADDR_RESET_CONTROL_STATUS, 8'h5c);
    setPtr(22'h00_0100);
    wr(ADDR_TABLE_LATCH, 8'h34);
    cmd(1'b0, 1'b1, PTR_POST_INC);
    wr(ADDR_TABLE_LATCH, 8'h12);
    cmd(1'b0, 1'b1, PTR_KEEP);
    `CHK(longCount, 8'h01)
    `CHK(lastWord, 16'h1234)
    `CHK(lastAddr[20:1], 20'h0_0080)
    `CHK(haltSeen >= 5, 1'b1)
    // No programming voltage: odd write issues no memory write
    @(posedge clk);
    programVoltagePin <= 1'b0;
    repeat (4) @(posedge clk);
    cmd(1'b0, 1'b1, PTR_KEEP);
    `CHK(longCount, 8'h01)
    // External memory ignores the cleared enable
    ev(1);
    rd(ADDR_RESET_CONTROL_STATUS, 8'h1c);
    @(posedge clk);
    externalMem <= 1'b1;
    setPtr(22'h00_0100);
    cmd(1'b0, 1'b1, PTR_POST_INC);
    cmd(1'b0, 1'b1, PTR_KEEP);
    `CHK(longCount, 8'h02)
    // Identification space refuses writes
    setPtr(22'h20_0101);
    cmd(1'b0, 1'b1, PTR_KEEP);
    `CHK(faultSeen, 1'b1)
    `CHK(longCount, 8'h02)
    // A brown-out three cycles into a long write ends it early
    setPtr(22'h00_0101);
    fork
      cmd(1'b0, 1'b1, PTR_KEEP);
      begin
        repeat (3) @(posedge clk);
        ev(2);
      end
    join
    `CHK(haltSeen, 3)
    `CHK(longCount, 8'h03)
    print_verdict();
  end
endmodule : test_table_read_write_unit
